/* hw/wdt_core.v */
// watchdog control and reset cause status registers
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_core #(
  parameter P_TICK_DIV = `WDT_REF_HZ / `WDT_OSC_HZ
) (
  input  wire       i_ref_clk,
  input  wire       i_reset,
  input  wire [7:0] i_bus_addr,
  input  wire       i_bus_io,
  input  wire       i_bus_wr,
  input  wire       i_bus_rd,
  input  wire [7:0] i_bus_wdata,
  output reg  [7:0] o_bus_rdata,
  input  wire       i_pin_rst_cause,
  input  wire       i_bod_rst_cause,
  input  wire       i_scan_rst_cause,
  input  wire       i_always_on_fuse_n,
  input  wire       i_gie,
  input  wire       i_irq_vector_ack,
  input  wire       i_wdr,
  output reg        o_wdt_irq,
  output reg        o_wdt_sys_rst
);

  // ****************************************
  // declarations
  // ****************************************
  reg  [3:0] sync1_ff;
  reg  [3:0] sync2_ff;
  reg        por_pend_ff;
  reg  [4:0] stat_ff;
  reg  [4:0] nxt_stat;
  reg        timeout_irq_flag_ff;
  reg        timeout_irq_enable_ff;
  reg        wde_ff;
  reg        change_enable_ff;
  reg  [3:0] ps_ff;
  reg  [2:0] ce_cnt_ff;
  reg        nxt_timeout_irq_flag;
  reg        nxt_timeout_irq_enable;
  reg        nxt_wde;
  reg        nxt_change_enable;
  reg  [3:0] nxt_ps;
  reg  [2:0] nxt_ce_cnt;
  reg  [7:0] nxt_rdata;
  wire       hit_stat;
  wire       hit_ctrl;
  wire       wr_stat;
  wire       wr_ctrl;
  wire       fuse_prog;
  wire       eff_wde;
  wire       eff_ie;
  wire       run;
  wire       timeout;
  wire       rst_req;
  wire       set_if;
  wire       ext_rst;
  wire [4:0] stat_set;
  wire [7:0] ctrl_rd;

  // ****************************************
  // address decode
  // ****************************************
  function reg_match;
    input       io;
    input [7:0] addr;
    input [7:0] off;
    begin
      if (io) begin
        reg_match = (off < `WDT_EXT_BASE) && (addr == off - `WDT_IO_BASE);
      end else begin
        reg_match = (addr == off);
      end
    end
  endfunction

  assign hit_stat = reg_match(i_bus_io, i_bus_addr, `WDT_STATUS_OFF);
  assign hit_ctrl = reg_match(i_bus_io, i_bus_addr, `WDT_CTRL_OFF);
  assign wr_stat  = i_bus_wr & hit_stat;
  assign wr_ctrl  = i_bus_wr & hit_ctrl;

  // ****************************************
  // input synchronisers
  // ****************************************
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff <= 4'h8;
      sync2_ff <= 4'h8;
    end else begin
      sync1_ff <= {i_always_on_fuse_n, i_scan_rst_cause,
                   i_bod_rst_cause, i_pin_rst_cause};
      sync2_ff <= sync1_ff;
    end
  end

  assign fuse_prog = ~sync2_ff[3];
  assign ext_rst   = sync2_ff[2] | sync2_ff[1] | sync2_ff[0];

  // ****************************************
  // mode selection
  // ****************************************
  // reset flag overrides enable
  assign eff_wde = wde_ff | stat_ff[`WDT_WDRST_BIT] | fuse_prog;
  assign eff_ie  = timeout_irq_enable_ff & ~fuse_prog;
  assign run     = eff_wde | eff_ie;
  assign rst_req = timeout & eff_wde & (~eff_ie | timeout_irq_flag_ff);
  assign set_if  = timeout & eff_ie;

  wdt_tick_cnt #(
    .P_TICK_DIV (P_TICK_DIV)
  ) u_cnt (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_run      (run),
    .i_restart  (i_wdr),
    .i_prescale (ps_ff),
    .o_timeout  (timeout)
  );

  // ****************************************
  // reset cause status
  // ****************************************
  // set sources for the scan, watchdog, brown-out, pin and power-on reset flags
  assign stat_set = {sync2_ff[2], o_wdt_sys_rst, sync2_ff[1], sync2_ff[0], por_pend_ff};

  always @* begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & i_bus_wdata[4:0];
    end
    nxt_stat = nxt_stat | stat_set;
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      por_pend_ff <= 1'b1;
      stat_ff     <= `WDT_STATUS_RST;
    end else begin
      por_pend_ff <= 1'b0;
      stat_ff     <= nxt_stat;
    end
  end

  // ****************************************
  // watchdog control
  // ****************************************
  always @* begin
    nxt_timeout_irq_flag   = timeout_irq_flag_ff;
    nxt_timeout_irq_enable   = timeout_irq_enable_ff;
    nxt_wde    = wde_ff;
    nxt_change_enable   = change_enable_ff;
    nxt_ps     = ps_ff;
    nxt_ce_cnt = ce_cnt_ff;
    if (wr_ctrl) begin
      nxt_timeout_irq_enable = i_bus_wdata[`WDT_IE_BIT];
      if (change_enable_ff) begin
        nxt_wde = i_bus_wdata[`WDT_RE_BIT];
        nxt_ps  = {i_bus_wdata[`WDT_PS3_BIT], i_bus_wdata[`WDT_PS_HI:0]};
      end else begin
        nxt_wde = wde_ff | i_bus_wdata[`WDT_RE_BIT];
      end
      nxt_change_enable   = i_bus_wdata[`WDT_CE_BIT] & i_bus_wdata[`WDT_RE_BIT];
      nxt_ce_cnt = nxt_change_enable ? `WDT_CE_CYCLES : 3'h0;
      if (i_bus_wdata[`WDT_IF_BIT]) begin
        nxt_timeout_irq_flag = 1'b0;
      end
    end else if (ce_cnt_ff != 3'h0) begin
      nxt_ce_cnt = ce_cnt_ff - 3'h1;
      if (ce_cnt_ff == 3'h1) begin
        nxt_change_enable = 1'b0;
      end
    end
    if (i_irq_vector_ack) begin
      nxt_timeout_irq_flag = 1'b0;
      if (eff_wde) begin
        nxt_timeout_irq_enable = 1'b0;
      end
    end
    if (set_if) begin
      nxt_timeout_irq_flag = 1'b1;
    end
    if (o_wdt_sys_rst || ext_rst) begin
      nxt_timeout_irq_flag   = 1'b0;
      nxt_timeout_irq_enable   = 1'b0;
      nxt_wde    = 1'b0;
      nxt_change_enable   = 1'b0;
      nxt_ps     = 4'h0;
      nxt_ce_cnt = 3'h0;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      timeout_irq_flag_ff   <= 1'b0;
      timeout_irq_enable_ff   <= 1'b0;
      wde_ff    <= 1'b0;
      change_enable_ff   <= 1'b0;
      ps_ff     <= 4'h0;
      ce_cnt_ff <= 3'h0;
    end else begin
      timeout_irq_flag_ff   <= nxt_timeout_irq_flag;
      timeout_irq_enable_ff   <= nxt_timeout_irq_enable;
      wde_ff    <= nxt_wde;
      change_enable_ff   <= nxt_change_enable;
      ps_ff     <= nxt_ps;
      ce_cnt_ff <= nxt_ce_cnt;
    end
  end

  // ****************************************
  // read data and outputs
  // ****************************************
  assign ctrl_rd = {timeout_irq_flag_ff, eff_ie, ps_ff[3], change_enable_ff, eff_wde, ps_ff[2:0]};

  always @* begin
    nxt_rdata = 8'h00;
    if (i_bus_rd && hit_stat) begin
      nxt_rdata = {3'h0, stat_ff};
    end else if (i_bus_rd && hit_ctrl) begin
      nxt_rdata = ctrl_rd;
    end
  end

  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_rdata   <= 8'h00;
      o_wdt_irq     <= 1'b0;
      o_wdt_sys_rst <= 1'b0;
    end else begin
      o_bus_rdata   <= nxt_rdata;
      o_wdt_irq     <= i_gie & eff_ie & timeout_irq_flag_ff;
      o_wdt_sys_rst <= rst_req;
    end
  end

endmodule

/* pkg/wdt_regs.vh */
// register offsets, field positions, reset values and timing for the watchdog block
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define WDT_STATUS_OFF   8'h54
`define WDT_CTRL_OFF     8'h60
`define WDT_IO_BASE      8'h20
`define WDT_EXT_BASE     8'h60

// ****************************************
// reset_cause_status fields
// ****************************************
`define WDT_SCAN_BIT     4
`define WDT_WDRST_BIT    3
`define WDT_BOD_BIT      2
`define WDT_PIN_BIT      1
`define WDT_POR_BIT      0
`define WDT_STATUS_RST   5'h00

// ****************************************
// watchdog_control fields
// ****************************************
`define WDT_IF_BIT       7
`define WDT_IE_BIT       6
`define WDT_PS3_BIT      5
`define WDT_CE_BIT       4
`define WDT_RE_BIT       3
`define WDT_PS_HI        2
`define WDT_CTRL_RST     8'h00

// ****************************************
// timing
// ****************************************
`define WDT_REF_HZ       10000000
`define WDT_OSC_HZ       128000
`define WDT_CE_CYCLES    3'h4
`define WDT_BASE_TICKS   21'h000800
`define WDT_PS_MAX       4'h9

`endif

/* hw/wdt_tick_cnt.v */
// watchdog oscillator tick divider and timeout counter
`timescale 1ns/1ps
`include "wdt_regs.vh"

module wdt_tick_cnt #(
  parameter P_TICK_DIV = 78
) (
  input  wire       i_ref_clk,
  input  wire       i_reset,
  input  wire       i_run,
  input  wire       i_restart,
  input  wire [3:0] i_prescale,
  output reg        o_timeout
);

  localparam integer DIV_LAST_I = P_TICK_DIV - 1;
  localparam [15:0]  DIV_LAST   = DIV_LAST_I[15:0];

  reg  [15:0] div_ff;
  reg  [20:0] cnt_ff;
  wire        tick;
  wire [20:0] lim_last;

  // ****************************************
  // timeout length
  // ****************************************
  // prescale to cycles
  function [20:0] wdt_limit;
    input [3:0] ps;
    reg   [3:0] code;
    begin
      code = (ps > `WDT_PS_MAX) ? `WDT_PS_MAX : ps;
      wdt_limit = `WDT_BASE_TICKS << code;
    end
  endfunction

  assign lim_last = wdt_limit(i_prescale) - 21'h000001;
  assign tick = (div_ff == DIV_LAST);

  // ****************************************
  // counter
  // ****************************************
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      div_ff    <= 16'h0000;
      cnt_ff    <= 21'h000000;
      o_timeout <= 1'b0;
    end else if (!i_run || i_restart) begin
      div_ff    <= 16'h0000;
      cnt_ff    <= 21'h000000;
      o_timeout <= 1'b0;
    end else begin
      div_ff    <= tick ? 16'h0000 : div_ff + 16'h0001;
      o_timeout <= 1'b0;
      if (tick) begin
        if (cnt_ff >= lim_last) begin
          cnt_ff    <= 21'h000000;
          o_timeout <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 21'h000001;
        end
      end
    end
  end

endmodule

/* test/wdt_core_chk.sv */
// port checker for the watchdog core
`timescale 1ns/1ps
module wdt_core_chk (
  input wire       i_ref_clk,
  input wire       i_reset,
  input wire [7:0] i_bus_addr,
  input wire       i_bus_io,
  input wire       i_bus_rd,
  input wire       i_always_on_fuse_n,
  input wire       i_gie,
  input wire       i_irq_vector_ack,
  input wire       i_wdr,
  input wire [7:0] o_bus_rdata,
  input wire       o_wdt_irq,
  input wire       o_wdt_sys_rst
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire st_hit = i_bus_rd & (i_bus_io ? i_bus_addr == 8'h34 : i_bus_addr == 8'h54);
  wire ct_hit = i_bus_rd & ~i_bus_io & (i_bus_addr == 8'h60);
  wire no_hit = i_bus_rd & ~st_hit & ~ct_hit;
  chk_pulse_one: assert property (o_wdt_sys_rst |=> !o_wdt_sys_rst [*8])
    else $error("reset pulse too long");
  chk_irq_gie: assert property (o_wdt_irq |-> $past(i_gie))
    else $error("irq without global enable");
  chk_rdata_idle: assert property (!$past(i_bus_rd) |-> o_bus_rdata == 8'h00)
    else $error("read data without read");
  chk_unmapped_zero: assert property ($past(no_hit) |-> o_bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_status_top: assert property ($past(st_hit) |-> o_bus_rdata[7:5] == 3'h0)
    else $error("status upper bits set");
  chk_fuse_force: assert property ($past(ct_hit) && $past(i_always_on_fuse_n, 2) == 1'b0
    && $past(i_always_on_fuse_n, 3) == 1'b0 |-> o_bus_rdata[3] && !o_bus_rdata[6])
    else $error("fuse does not force reset mode");
  chk_ack_clears: assert property (i_irq_vector_ack |-> ##2 !o_wdt_irq)
    else $error("irq stays after vector");
  chk_wdr_quiet: assert property (i_wdr |-> ##3 !o_wdt_sys_rst [*8])
    else $error("reset right after restart");
  cover property (o_wdt_sys_rst);
  cover property (o_wdt_irq && i_irq_vector_ack);
  cover property (i_wdr);
endmodule

bind wdt_core wdt_core_chk i_wdt_core_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus_addr(i_bus_addr), .i_bus_io(i_bus_io),
  .i_bus_rd(i_bus_rd), .i_always_on_fuse_n(i_always_on_fuse_n), .i_gie(i_gie),
  .i_irq_vector_ack(i_irq_vector_ack), .i_wdr(i_wdr), .o_bus_rdata(o_bus_rdata),
  .o_wdt_irq(o_wdt_irq), .o_wdt_sys_rst(o_wdt_sys_rst));

/* test/wdt_core_tb_top.sv */
// self-checking bench for the watchdog core
`timescale 1ns/1ps
module wdt_core_tb_top;
  // ****************************************
  // stimulus and checks
  // ****************************************
  reg         i_ref_clk = 0;
  reg         i_reset = 1;
  reg  [7:0]  addr = 0, wdata = 0, st, v, d;
  reg         io = 0, wr = 0, rd = 0, pin = 0, bod = 0, scan = 0;
  reg         fuse_n = 1, gie = 0, ack = 0, wdr = 0;
  wire [7:0]  rdata;
  wire        irq, srst;
  integer     n_mismatch = 0, check_count = 0, seed = 33170, i, n, m, nrst = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (srst === 1'b1) nrst <= nrst + 1;
  wdt_core #(.P_TICK_DIV(2)) i_wdt_core (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus_addr(addr), .i_bus_io(io),
    .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
    .i_pin_rst_cause(pin), .i_bod_rst_cause(bod), .i_scan_rst_cause(scan),
    .i_always_on_fuse_n(fuse_n), .i_gie(gie), .i_irq_vector_ack(ack), .i_wdr(wdr),
    .o_wdt_irq(irq), .o_wdt_sys_rst(srst));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input f, input [7:0] dd);
    begin
      @(posedge i_ref_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      io <= f;
      wdata <= dd;
      @(posedge i_ref_clk);
      wr <= 0;
      rd <= 0;
      #1 v = rdata;
    end
  endtask
  task rchk(input [7:0] a, input f, input [7:0] exp);
    begin
      acc(0, a, f, 8'h00);
      chk(v, exp);
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  task pls(input s);
    begin
      @(posedge i_ref_clk);
      wdr <= !s;
      ack <= s;
      @(posedge i_ref_clk);
      wdr <= 0;
      ack <= 0;
    end
  endtask
  task wait_on(input s, input integer lim);
    begin
      n = 0;
      while ((s ? irq : srst) !== 1'b1 && n < lim) begin
        @(posedge i_ref_clk);
        #1 n = n + 1;
      end
      chk(n < lim, 8'h01);
      if (srst === 1'b1) st = st | 8'h08;
    end
  endtask
  task disarm;
    begin
      acc(1, 8'h54, 0, 8'h00);
      st = 8'h00;
      acc(1, 8'h60, 0, 8'h18);
      acc(1, 8'h60, 0, 8'h00);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #8000000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    cyc(3);
    i_reset <= 0;
    st = 8'h01;
    cyc(2);
    rchk(8'h54, 0, 8'h01);
    rchk(8'h34, 1, 8'h01);
    rchk(8'h40, 1, 8'h00);
    rchk(8'h55, 0, 8'h00);
    rchk(8'h60, 0, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge i_ref_clk);
      pin <= i == 0;
      bod <= i == 1;
      scan <= i == 2;
      cyc(6);
      pin <= 0;
      bod <= 0;
      scan <= 0;
      cyc(4);
      st = st | (i == 2 ? 8'h10 : 8'h02 << i);
      rchk(8'h54, 0, st);
      d = $random(seed);
      acc(1, 8'h34, 1, d);
      st = st & d;
      rchk(8'h54, 0, st);
    end
    for (i = 0; i < 2; i = i + 1) begin
      disarm;
      acc(1, 8'h60, 0, 8'h18);
      acc(1, 8'h60, 0, 8'h08 | i);
      wait_on(0, 20000);
      chk(n >= (4096 << i) - 8 && n <= (4096 << i) + 8, 8'h01);
      rchk(8'h54, 0, st);
    end
    rchk(8'h60, 0, 8'h08);
    acc(1, 8'h60, 0, 8'h18);
    acc(1, 8'h60, 0, 8'h00);
    rchk(8'h60, 0, 8'h08);
    acc(1, 8'h54, 0, 8'h00);
    acc(1, 8'h60, 0, 8'h18);
    cyc(5);
    acc(1, 8'h60, 0, 8'h00);
    rchk(8'h60, 0, 8'h08);
    disarm;
    rchk(8'h60, 0, 8'h00);
    m = nrst;
    acc(1, 8'h60, 0, 8'h08);
    repeat (3) begin
      cyc(3000);
      pls(0);
    end
    chk(nrst == m, 8'h01);
    d = $random(seed);
    acc(1, 8'h60, 0, 8'h18);
    acc(1, 8'h60, 0, {2'h0, d[3], 2'h0, d[2:0]});
    rchk(8'h60, 0, {2'h0, d[3], 2'h0, d[2:0]});
    disarm;
    gie <= 1;
    acc(1, 8'h60, 0, 8'h48);
    wait_on(1, 5000);
    rchk(8'h60, 0, 8'hC8);
    pls(1);
    cyc(2);
    #1 chk(irq, 8'h00);
    rchk(8'h60, 0, 8'h08);
    wait_on(0, 5000);
    chk(srst, 8'h01);
    @(posedge i_ref_clk);
    #1 chk(srst, 8'h00);
    acc(1, 8'h60, 0, 8'h48);
    wait_on(1, 5000);
    wait_on(0, 5000);
    chk(srst, 8'h01);
    disarm;
    gie <= 0;
    acc(1, 8'h60, 0, 8'h40);
    cyc(4300);
    #1 chk(irq, 8'h00);
    rchk(8'h60, 0, 8'hC0);
    acc(1, 8'h60, 0, 8'hC0);
    rchk(8'h60, 0, 8'h40);
    fuse_n <= 0;
    cyc(4);
    rchk(8'h60, 0, 8'h08);
    final_report;
  end
endmodule
